/* File: rtl/apd_pkg.sv */
/*
 * Constants, types and the operation list for the serial command port and
 * power-down manager of a sampling converter.
 * Assumes a single core clock; link pins are sampled by that clock.
 */
package apd_pkg;
    localparam int          CMD_W         = 4;
    localparam int          CFG_W         = 12;
    localparam int          RES_W         = 14;
    localparam logic [3:0]  CMD_WAKE      = 4'hB;
    localparam logic [3:0]  CMD_RD_CFG    = 4'hC;
    localparam logic [3:0]  CMD_RD_DATA   = 4'hD;
    localparam logic [3:0]  CMD_WR_CFG    = 4'hE;
    localparam logic [3:0]  CMD_DEFAULT   = 4'hF;
    localparam logic [11:0] CFG_RESET     = 12'hFFF;
    localparam int          BIT_DEEP      = 2;
    localparam int          BIT_NAP       = 3;
    localparam int          BIT_AUTO_NAP  = 4;
    localparam logic [4:0]  CMD_EDGE      = 5'h04;
    localparam logic [4:0]  WORD_EDGE     = 5'h10;
    localparam logic [4:0]  MAX_EDGE      = 5'h18;
    localparam int          CONV_TICKS    = 18;
    localparam int          NAP_WAKE_TICKS = 3;
    localparam int          CLK_PERIOD_PS = 4000;
    localparam int          DEEP_WAKE_NS  = 1000;
    localparam int          DEEP_WAKE_CYC = (DEEP_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        PM_RUN  = 2'b00,
        PM_DEEP = 2'b01,
        PM_NAP  = 2'b10,
        PM_AUTO = 2'b11
    } apd_pm_e;

    // Word handed from the frame decoder to the buffer
    typedef struct packed {
        logic [3:0]  cmd;
        logic [11:0] data;
        logic        full;
    } apd_word_s;
endpackage : apd_pkg

/* File: rtl/apd_port.sv */
/*
 * Serial command port and power-down manager.
 * Assumes the serial clock, frame select, data in and conversion start come
 * from outside the core clock domain; the serial clock is at least 4x slower.
 */
`timescale 1ns/1ps
module apd_port #(
    parameter int DEEP_WAKE = apd_pkg::DEEP_WAKE_CYC
) (
    input  wire logic                      core_clk_in,       // Core clock 250 MHz
    input  wire logic                      rst_in,            // Async reset, high
    input  wire logic                      sclk_in,           // Serial clock pin
    input  wire logic                      frame_select_n_in, // Frame select, low active
    input  wire logic                      sdi_in,            // Serial data in
    input  wire logic                      conversion_start_n_in, // Conversion start, low active
    input  wire logic                      conversion_clock_tick_in, // One pulse per conversion clock
    input  wire logic [apd_pkg::RES_W-1:0] result_in,         // Latched conversion result
    output logic                           sdo_out,           // Serial data out
    output logic                           sdo_oe_out,        // Data out driven
    output logic [apd_pkg::CFG_W-1:0]      cfg_out,           // Configuration word
    output logic                           channel_out,       // Selected input
    output logic                           converting_out,    // Conversion busy
    output logic                           powered_down_out,  // Any power-down active
    output logic                           osc_off_out,       // Oscillator stopped (deep)
    output logic                           ready_out          // Wake period over
);
    // Two-stage synchronisers on the serial clock, frame select, data in and conversion start pins
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic       sclk_prev_q;
    logic       fs_prev_q;
    logic       cs_prev_q;
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            s1_q        <= 4'hF;
            s2_q        <= 4'hF;
            sclk_prev_q <= 1'b1;
            fs_prev_q   <= 1'b1;
            cs_prev_q   <= 1'b1;
        end
        else
        begin
            s1_q        <= {conversion_start_n_in, sdi_in, frame_select_n_in, sclk_in};
            s2_q        <= s1_q;
            sclk_prev_q <= s2_q[0];
            fs_prev_q   <= s2_q[1];
            cs_prev_q   <= s2_q[3];
        end
    end

    logic sclk_fall;
    logic fs_fall;
    logic cs_fall;
    logic frame_on;
    assign frame_on  = ~s2_q[1];
    assign sclk_fall = sclk_prev_q & ~s2_q[0] & frame_on;
    assign fs_fall   = fs_prev_q & ~s2_q[1];
    assign cs_fall   = cs_prev_q & ~s2_q[3];

    // Frame shifter: edge count and input word
    // The count stops at 24, so an overlong frame never reaches edge 4 or 16
    // a second time and cannot post a stray command
    logic [4:0]  edge_q;
    logic [15:0] shin_q;
    logic [15:0] shin_d;
    assign shin_d = {shin_q[14:0], s2_q[2]};
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            edge_q <= 5'h00;
            shin_q <= 16'h0000;
        end
        else if (fs_fall)
        begin
            edge_q <= 5'h00;
            shin_q <= 16'h0000;
        end
        else if (sclk_fall && edge_q != apd_pkg::MAX_EDGE)
        begin
            edge_q <= edge_q + 5'h01;
            shin_q <= shin_d;
        end
    end

    // Frame decoder posts words; a command at edge 4, a write at edge 16
    logic            cmd_ev;
    logic            word_ev;
    apd_pkg::apd_word_s in_word;
    assign cmd_ev  = sclk_fall && (edge_q + 5'h01) == apd_pkg::CMD_EDGE;
    assign word_ev = sclk_fall && (edge_q + 5'h01) == apd_pkg::WORD_EDGE
                     && shin_q[14:11] == apd_pkg::CMD_WR_CFG;
    assign in_word.cmd  = word_ev ? shin_q[14:11] : shin_d[3:0];
    assign in_word.data = {shin_q[10:0], s2_q[2]};
    assign in_word.full = word_ev;

    // Two-entry buffer between decoder and executor
    // A word that meets a full buffer is dropped; frames are far slower than
    // the executor, so only a long run of stalls could fill it
    apd_pkg::apd_word_s buf_q [2];
    logic [1:0] cnt_q;
    logic       rd_ptr_q;
    logic       wr_ptr_q;
    logic       in_valid;
    logic       in_ready;
    logic       out_valid;
    logic       out_ready;
    assign in_valid  = cmd_ev | word_ev;
    assign in_ready  = cnt_q != 2'h2;
    assign out_valid = cnt_q != 2'h0;
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cnt_q    <= 2'h0;
            rd_ptr_q <= 1'b0;
            wr_ptr_q <= 1'b0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
        end
        else
        begin
            if (in_valid && in_ready)
            begin
                buf_q[wr_ptr_q] <= in_word;
                wr_ptr_q        <= ~wr_ptr_q;
            end
            if (out_valid && out_ready)
                rd_ptr_q <= ~rd_ptr_q;
            cnt_q <= cnt_q + {1'b0, in_valid && in_ready} - {1'b0, out_valid && out_ready};
        end
    end

    // Conversion state, declared here because the executor watches it
    logic       conv_q;
    logic [4:0] conv_cnt_q;
    logic       end_conv;
    assign end_conv = conv_q && conversion_clock_tick_in && conv_cnt_q == 5'h01;

    // Command decodes shared by the config and power-state logic
    function automatic logic cmd_is_wake(input logic [3:0] code);
        return code == apd_pkg::CMD_WAKE;
    endfunction : cmd_is_wake

    // Codes 0..7 (channel selects and unused low codes), default and wake all end an auto-nap
    function automatic logic cmd_wakes_auto(input logic [3:0] code);
        return code[3] == 1'b0 || code == apd_pkg::CMD_DEFAULT || cmd_is_wake(code);
    endfunction : cmd_wakes_auto

    apd_pkg::apd_word_s ex;
    assign ex        = buf_q[rd_ptr_q];
    // Executor stalls on the last conversion tick, so that a wake command
    // and the auto-nap entry never land in the same cycle
    assign out_ready = ~end_conv;

    // Configuration word; power-down never writes it here
    logic [apd_pkg::CFG_W-1:0] cfg_q;
    logic                      chan_q;
    logic                      take;
    assign take = out_valid && out_ready;
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            cfg_q  <= apd_pkg::CFG_RESET;
            chan_q <= 1'b0;
        end
        else if (take)
        begin
            if (ex.full)
                cfg_q <= ex.data;
            else if (ex.cmd == apd_pkg::CMD_DEFAULT)
                cfg_q <= apd_pkg::CFG_RESET;
            else if (cmd_is_wake(ex.cmd))
            begin
                cfg_q[apd_pkg::BIT_DEEP] <= 1'b1;
                cfg_q[apd_pkg::BIT_NAP]  <= 1'b1;
            end
            else if (ex.cmd[3:1] == 3'b000)
                chan_q <= ex.cmd[0];
            // Codes 2..7, reserved and read codes change nothing here
        end
    end

    // Power state
    // Commands wake through the executor; the start pin wakes auto-nap directly
    logic wake_cmd;
    logic auto_wake;
    assign wake_cmd  = take && !ex.full && cmd_is_wake(ex.cmd);
    assign auto_wake = take && !ex.full && cmd_wakes_auto(ex.cmd);
    apd_pkg::apd_pm_e pm_q;
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            pm_q <= apd_pkg::PM_RUN;
        else
        begin
            case (pm_q)
                apd_pkg::PM_RUN:
                begin
                    if (!cfg_q[apd_pkg::BIT_DEEP])
                        pm_q <= apd_pkg::PM_DEEP;
                    else if (!cfg_q[apd_pkg::BIT_NAP])
                        pm_q <= apd_pkg::PM_NAP;
                    else if (end_conv && !cfg_q[apd_pkg::BIT_AUTO_NAP])
                        pm_q <= apd_pkg::PM_AUTO;
                end
                apd_pkg::PM_DEEP:
                    if (cfg_q[apd_pkg::BIT_DEEP] || wake_cmd)
                        pm_q <= apd_pkg::PM_RUN;
                apd_pkg::PM_NAP:
                    if (cfg_q[apd_pkg::BIT_NAP] || wake_cmd)
                        pm_q <= apd_pkg::PM_RUN;
                apd_pkg::PM_AUTO:
                    if (cfg_q[apd_pkg::BIT_AUTO_NAP] || auto_wake || cs_fall)
                        pm_q <= apd_pkg::PM_RUN;
                default:
                    pm_q <= apd_pkg::PM_RUN;
            endcase
        end
    end

    // Wake timer: ticks for nap, core cycles for deep
    // Deep wake is counted in core cycles, so DEEP_WAKE must follow the core
    // clock; nap wake follows the conversion clock whatever its rate
    logic [15:0] wake_q;
    logic        wake_tick;
    logic        deep_wake_q;
    assign wake_tick = (pm_q == apd_pkg::PM_RUN) && wake_q != 16'h0000
                       && (deep_wake_q || conversion_clock_tick_in);
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            wake_q      <= 16'h0000;
            deep_wake_q <= 1'b0;
        end
        else if (pm_q == apd_pkg::PM_DEEP)
        begin
            wake_q      <= 16'(DEEP_WAKE);
            deep_wake_q <= 1'b1;
        end
        else if (pm_q != apd_pkg::PM_RUN)
        begin
            wake_q      <= 16'(apd_pkg::NAP_WAKE_TICKS);
            deep_wake_q <= 1'b0;
        end
        else if (wake_tick)
            wake_q <= wake_q - 16'h0001;
    end

    // Conversion: aborted by nap or deep, held off while waking
    // Abort follows the config bits, so it lands in the same cycle as the power state change
    logic start_pend_q;
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            conv_q       <= 1'b0;
            conv_cnt_q   <= 5'h00;
            start_pend_q <= 1'b0;
        end
        else if (pm_q == apd_pkg::PM_DEEP || pm_q == apd_pkg::PM_NAP
                 || !cfg_q[apd_pkg::BIT_DEEP] || !cfg_q[apd_pkg::BIT_NAP])
        begin
            conv_q       <= 1'b0;
            start_pend_q <= 1'b0;
        end
        else if ((cs_fall || start_pend_q) && !conv_q)
        begin
            if (pm_q == apd_pkg::PM_RUN && wake_q == 16'h0000)
            begin
                conv_q       <= 1'b1;
                conv_cnt_q   <= 5'(apd_pkg::CONV_TICKS);
                start_pend_q <= 1'b0;
            end
            else
                start_pend_q <= 1'b1;
        end
        else if (conv_q && conversion_clock_tick_in)
        begin
            conv_cnt_q <= conv_cnt_q - 5'h01;
            if (conv_cnt_q == 5'h01)
                conv_q <= 1'b0;
        end
    end

    // Output shifter: result MSB at frame start, read-config puts cfg below
    // The four result MSBs leave before the config word replaces them
    logic [15:0] shout_q;
    logic        rd_cfg_q;
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            shout_q  <= 16'h0000;
            rd_cfg_q <= 1'b0;
        end
        else if (fs_fall)
        begin
            shout_q  <= {result_in, 2'b00};
            rd_cfg_q <= 1'b0;
        end
        else if (sclk_fall)
        begin
            if (cmd_ev && shin_d[3:0] == apd_pkg::CMD_RD_CFG && !rd_cfg_q)
            begin
                shout_q  <= {cfg_q, 4'h0};
                rd_cfg_q <= 1'b1;
            end
            else
                shout_q <= {shout_q[14:0], 1'b0};
        end
    end

    // Registered outputs
    // Status lags its state by one cycle; every output leaves a flip-flop
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sdo_out          <= 1'b0;
            sdo_oe_out       <= 1'b0;
            cfg_out          <= apd_pkg::CFG_RESET;
            channel_out      <= 1'b0;
            converting_out   <= 1'b0;
            powered_down_out <= 1'b0;
            osc_off_out      <= 1'b0;
            ready_out        <= 1'b1;
        end
        else
        begin
            sdo_out          <= shout_q[15];
            sdo_oe_out       <= frame_on;
            cfg_out          <= cfg_q;
            channel_out      <= chan_q;
            converting_out   <= conv_q;
            powered_down_out <= pm_q != apd_pkg::PM_RUN;
            osc_off_out      <= pm_q == apd_pkg::PM_DEEP;
            ready_out        <= pm_q == apd_pkg::PM_RUN && wake_q == 16'h0000;
        end
    end
endmodule : apd_port

/* File: tb/apd_host.sv */
/* Host model: serial bus master sending frames MSB first.
   Assumes its caller enters frame() just after a core clock fall. */
`timescale 1ns/1ps
module apd_host (
    input  wire logic core_clk_in, // Paces the link, 32 ns
    output logic      sclk_out,    // Idles high between frames
    output logic      fs_n_out,    // Frame select
    output logic      sdi_out,     // Data to device
    input  wire logic sdo_in       // Data from device
);
    // Parked levels; data parks at the inverse of its last bit
    initial
    begin
        sclk_out = 1'b1;
        fs_n_out = 1'b1;
        sdi_out = 1'b0;
    end
    task automatic half();
        repeat (4) @(negedge core_clk_in);
    endtask : half
    // Frame of n falling edges; rx gathers data out at each fall
    task automatic frame(input logic [15:0] w, input int n, output logic [23:0] rx);
        fs_n_out = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            sdi_out = (i < 16) ? w[15 - i] : ~sdi_out;
            half();
            rx = {rx[22:0], sdo_in};
            sclk_out = 1'b0;
            half();
            sclk_out = 1'b1;
        end
        half();
        fs_n_out = 1'b1;
        sdi_out = ~sdi_out;
        repeat (8) @(negedge core_clk_in);
    endtask : frame
endmodule : apd_host

/* File: tb/apd_port_props.sv */
/* Timing checks on the command port's pins and status outputs.
   Assumes one core clock domain and an active-high reset. */
`timescale 1ns/1ps
module apd_port_props #(
    parameter int DEEP_WAKE = apd_pkg::DEEP_WAKE_CYC
) (
    input wire logic        core_clk_in,              // Core clock
    input wire logic        rst_in,                   // Reset
    input wire logic        frame_select_n_in,        // Frame select
    input wire logic        conversion_clock_tick_in, // Tick
    input wire logic        sdo_oe_out,               // Out enable
    input wire logic [11:0] cfg_out,                  // Config word
    input wire logic        converting_out,           // Busy
    input wire logic        powered_down_out,         // Asleep
    input wire logic        osc_off_out,              // Deep
    input wire logic        ready_out                 // Awake
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic [15:0] fs_hi_q;
    logic [15:0] cyc_q;
    logic [3:0]  tick_q;
    logic        deep_q;
    // Idle time since the last frame; config may only move near a frame
    always_ff @(posedge core_clk_in or posedge rst_in)
        if (rst_in) fs_hi_q <= 16'h0000;
        else if (!frame_select_n_in) fs_hi_q <= 16'h0000;
        else if (fs_hi_q != 16'hFFFF) fs_hi_q <= fs_hi_q + 16'h0001;
    // Wake timers restart while asleep
    always_ff @(posedge core_clk_in or posedge rst_in)
        if (rst_in) cyc_q <= 16'h0000;
        else if (powered_down_out) cyc_q <= 16'h0000;
        else if (cyc_q != 16'hFFFF) cyc_q <= cyc_q + 16'h0001;
    always_ff @(posedge core_clk_in or posedge rst_in)
        if (rst_in) tick_q <= 4'h0;
        else if (powered_down_out) tick_q <= 4'h0;
        else if (conversion_clock_tick_in && tick_q != 4'hF) tick_q <= tick_q + 4'h1;
    // Remembers that the sleep being left was deep
    always_ff @(posedge core_clk_in or posedge rst_in)
        if (rst_in) deep_q <= 1'b0;
        else if (osc_off_out) deep_q <= 1'b1;
        else if (ready_out) deep_q <= 1'b0;
    sequence s_fs_fall;
        $fell(frame_select_n_in);
    endsequence
    sequence s_oe_up;
        ##[1:5] sdo_oe_out;
    endsequence
    a_reset_cfg_ones: assert property ($fell(rst_in) |-> cfg_out == 12'hFFF)
        else $error("config not all ones after reset");
    a_cfg_frame_only: assert property (!$stable(cfg_out) |-> fs_hi_q < 16'h0010)
        else $error("config changed outside a frame");
    a_oe_frame_on: assert property (s_fs_fall |-> s_oe_up)
        else $error("data out not driven in frame");
    a_oe_frame_off: assert property ($rose(frame_select_n_in) |-> ##[1:5] !sdo_oe_out)
        else $error("data out driven after frame");
    a_deep_osc_pd: assert property (osc_off_out |-> powered_down_out)
        else $error("oscillator off while awake");
    a_pd_abort_conv: assert property ($rose(powered_down_out) |-> ##[0:2] !converting_out)
        else $error("conversion survived power-down");
    a_start_held: assert property ($rose(converting_out) |-> ready_out && !powered_down_out)
        else $error("conversion started while waking");
    // A tick on the first awake edge goes uncounted while powered_down_out still lags, hence two or three counted
    a_nap_wake_ticks: assert property ($rose(ready_out) && !deep_q |-> tick_q >= 4'h2 && tick_q <= 4'h3)
        else $error("nap wake shorter than three ticks");
    a_deep_wake_time: assert property ($rose(ready_out) && deep_q |-> cyc_q + 2 >= DEEP_WAKE && cyc_q <= DEEP_WAKE + 2)
        else $error("deep wake too short");
endmodule : apd_port_props
bind apd_port apd_port_props #(.DEEP_WAKE(DEEP_WAKE)) props_u (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .frame_select_n_in(frame_select_n_in),
    .conversion_clock_tick_in(conversion_clock_tick_in), .sdo_oe_out(sdo_oe_out),
    .cfg_out(cfg_out), .converting_out(converting_out), .powered_down_out(powered_down_out),
    .osc_off_out(osc_off_out), .ready_out(ready_out));

/* File: tb/apd_port_tb_top.sv */
/* Self-checking bench for the command port, with a host model.
   Assumes a 4 ns core clock and a shortened deep wake of 40 cycles. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
    begin \
        n_checks++; \
        if ((got) !== (ex)) \
        begin \
            errors++; \
            $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
        end \
    end
module apd_port_tb_top;
    logic        core_clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        conv_n = 1'b1;
    logic        tick = 1'b0;
    logic [13:0] result = 14'h0000;
    logic        sclk, fs_n, sdi, sdo, channel, converting, pd, osc_off, ready;
    logic [11:0] cfg;
    logic [23:0] rx;
    logic [15:0] lfsr_q = 16'h000B;
    logic [15:0] r;
    int          errors = 0;
    int          n_checks = 0;
    int          exp_cfg = 12'hFFF;
    int          tk = 0;
    always #2 core_clk_in = ~core_clk_in;
    // Conversion tick every 16 cycles, so a conversion outlasts a frame
    always @(negedge core_clk_in)
    begin
        tk <= tk + 1;
        tick <= (tk % 16 == 0);
    end
    apd_port #(.DEEP_WAKE(40)) dut_u (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .sclk_in(sclk), .frame_select_n_in(fs_n),
        .sdi_in(sdi), .conversion_start_n_in(conv_n), .conversion_clock_tick_in(tick),
        .result_in(result), .sdo_out(sdo), .sdo_oe_out(), .cfg_out(cfg), .channel_out(channel),
        .converting_out(converting), .powered_down_out(pd), .osc_off_out(osc_off), .ready_out(ready));
    apd_host host_u (.core_clk_in(core_clk_in), .sclk_out(sclk), .fs_n_out(fs_n), .sdi_out(sdi), .sdo_in(sdo));
    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction : rnd
    // Frame plus reference update of the config word
    task automatic send(input logic [3:0] c, input logic [11:0] d, input int n);
        host_u.frame({c, d}, n, rx);
        if (c == 4'hE && n >= 16) exp_cfg = d;
        if (c == 4'hF) exp_cfg = 12'hFFF;
        if (c == 4'hB) exp_cfg = exp_cfg | 12'h00C;
        `CHK("cfg", exp_cfg[11:0], cfg)
    endtask : send
    task automatic wait_lvl(ref logic s, input logic v);
        for (int k = 0; k < 2000 && s !== v; k++) @(negedge core_clk_in);
        // A level that never comes counts as a mismatch
        if (s !== v)
        begin
            errors++;
            $display("[FAIL] wait level expected %0h seen %0h", v, s);
        end
    endtask : wait_lvl
    task automatic conv_pulse();
        conv_n = 1'b0;
        repeat (3) @(negedge core_clk_in);
        conv_n = 1'b1;
        repeat (8) @(negedge core_clk_in);
    endtask : conv_pulse
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : close_out
    initial
    begin
        repeat (40000) @(posedge core_clk_in);
        errors++;
        close_out();
    end
    // Main sequence
    initial
    begin
        repeat (12) @(negedge core_clk_in);
        rst_in = 1'b0;
        repeat (4) @(negedge core_clk_in);
        `CHK("ready", 1'b1, ready)
        for (int c = 2; c < 8; c++)
        begin
            r = rnd();
            send(c[3:0], r[11:0], 16);
        end
        r = rnd();
        send(4'hE, r[11:0] | 12'h01C, 16);
        send(4'hE, 12'h01C, 4);
        for (int c = 1; c >= 0; c--)
        begin
            r = rnd();
            send(c[3:0], r[11:0], 4);
            `CHK("channel", c[0], channel)
        end
        r = rnd();
        result = r[13:0];
        send(4'hD, 12'h000, 16);
        `CHK("sdo bits", result, rx[15:2])
        send(4'hC, 12'h000, 16);
        `CHK("cfg read", exp_cfg[11:0], rx[11:0])
        `CHK("cfg read msbs", result[13:10], rx[15:12])
        send(4'hF, 12'h000, 4);
        conv_pulse();
        `CHK("busy", 1'b1, converting)
        send(4'hE, 12'hFF7, 16);
        `CHK("abort", 1'b0, converting)
        `CHK("nap", 2'b10, {pd, osc_off})
        send(4'hE, 12'hFFF, 16);
        wait_lvl(ready, 1'b1);
        `CHK("nap left", 1'b0, pd)
        send(4'hE, 12'hFE7, 16);
        send(4'hB, 12'h123, 4);
        wait_lvl(ready, 1'b1);
        conv_pulse();
        wait_lvl(converting, 1'b0);
        repeat (4) @(negedge core_clk_in);
        `CHK("auto nap", 1'b1, pd)
        conv_pulse();
        wait_lvl(converting, 1'b1);
        `CHK("woke", 2'b10, {converting, pd})
        wait_lvl(converting, 1'b0);
        send(4'h0, 12'hABC, 4);
        wait_lvl(ready, 1'b1);
        `CHK("chan wake", 1'b0, pd)
        conv_pulse();
        wait_lvl(converting, 1'b0);
        send(4'hE, 12'hFFB, 16);
        `CHK("deep", 2'b11, {pd, osc_off})
        send(4'hB, 12'h000, 4);
        `CHK("deep wait", 1'b0, ready)
        wait_lvl(ready, 1'b1);
        `CHK("deep left", 2'b00, {pd, osc_off})
        close_out();
    end
endmodule : apd_port_tb_top
